// ### tb/asp_monitor.sv
// Purpose: port assertions for asp_top
// Assumes: bound from the bench top file
// Notes: shadows the control and divisor writes
`timescale 1ns/1ps
module asp_monitor (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  // serial link and interrupt
  input wire logic RXD,
  input wire logic TXD,
  input wire logic IRQ
);
  logic [15:0] ctrl;
  logic [15:0] div;
  logic [23:0] low_run;
  wire irq_en = ctrl[11] | ctrl[10] | ctrl[1];
  wire [23:0] bit_len = {4'h0, div, 4'h0};
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl <= 16'h0000;
      div <= 16'h0000;
    end else if (WR && ADDR == 8'h80) begin
      ctrl <= WDATA;
    end else if (WR && ADDR == 8'h88) begin
      div <= WDATA;
    end
  end
  // length of the current low stretch on the transmit line
  always_ff @(posedge SYS_CLK) begin
    low_run <= TXD ? 24'h000000 : low_run + 24'h000001;
  end
  sequence s_wr(a);
    WR && ADDR == a;
  endsequence
  sequence s_rd(a);
    RD && ADDR == a;
  endsequence
  AST_CTRL_BACK:
  assert property (s_wr(8'h80) ##2 s_rd(8'h80) |=> RDATA == ($past(WDATA, 3) & 16'h0FFF))
    else $error("control readback differs");
  AST_DIV_BACK:
  assert property (s_wr(8'h88) ##2 s_rd(8'h88) |=> RDATA == $past(WDATA, 3))
    else $error("divisor readback differs");
  AST_HOLD_CLR:
  assert property (s_wr(8'h84) ##0 !ctrl[2] ##2 s_rd(8'h82) |=> !RDATA[5])
    else $error("holding empty not cleared by write");
  AST_RX_CLR:
  assert property (s_rd(8'h86) ##2 s_rd(8'h82) |=> !RDATA[4])
    else $error("receive valid not cleared by read");
  AST_LOOP_TXD:
  assert property (ctrl[9] && $past(ctrl[9]) && $past(ctrl[9], 2) |-> TXD)
    else $error("transmit line low in loopback");
  AST_IRQ_OFF:
  assert property (!(irq_en || $past(irq_en) || $past(irq_en, 2)) |-> !IRQ)
    else $error("interrupt with all enables clear");
  AST_BIT_LEN:
  assert property ($rose(TXD) && !ctrl[9] && div != 16'h0000 |-> low_run % bit_len == 0)
    else $error("low stretch not whole bits");
  AST_START_HOLD:
  assert property ($fell(TXD) |-> !TXD [*8])
    else $error("transmit low bit too short");
  AST_TXD_RST:
  assert property ($past(RST) |-> TXD)
    else $error("transmit line not idle after reset");
endmodule

// ### tb/asp_rem.sv
// Purpose: remote serial station on the far side
// Assumes: bench sets nb, pm and ns; bit_clks stays 16
// Notes: receiver decodes every frame seen on txd
`timescale 1ns/1ps
module asp_rem (
  // clock
  input wire logic clk,
  // serial lines
  input wire logic txd,
  output logic rxd
);
  int bit_clks = 16;
  int nb = 8;
  logic [1:0] pm = 2'h0;
  int ns = 1;
  int n_got = 0;
  logic [7:0] got;
  logic got_p;
  logic got_stop;
  initial rxd = 1'b1;
  task automatic tx_bit(input logic b);
    rxd <= b;
    repeat (bit_clks) @(posedge clk);
  endtask
  // start, data lsb first, parity, stops, then idle high
  task automatic send(input logic [7:0] d, input logic bad, input logic stop_count_sel);
    @(posedge clk);
    tx_bit(1'b0);
    for (int i = 0; i < nb; i++) tx_bit(d[i]);
    if (pm[1]) tx_bit((pm[0] ? ^d : ~^d) ^ bad);
    repeat (ns) tx_bit(stop_count_sel);
    rxd <= 1'b1;
  endtask
  always begin
    @(negedge txd);
    repeat (bit_clks / 2) @(posedge clk);
    got = 8'h00;
    for (int i = 0; i < nb; i++) begin
      repeat (bit_clks) @(posedge clk);
      got[i] = txd;
    end
    if (pm[1]) begin
      repeat (bit_clks) @(posedge clk);
      got_p = txd;
    end
    repeat (bit_clks) @(posedge clk);
    got_stop = txd;
    n_got++;
  end
endmodule

// ### tb/asp_tb_top.sv
// Purpose: register-level bench for asp_top
// Assumes: divisor 1, so one bit is 16 clocks
// Notes: remote station drives RXD and decodes TXD
`timescale 1ns/1ps
module asp_tb_top;
  logic SYS_CLK, RST, WR, RD, RXD, TXD, IRQ;
  logic [7:0] ADDR, d, mk;
  logic [15:0] WDATA, RDATA, v;
  logic [15:0] cfg [3] = '{16'h0010, 16'h0040, 16'h0078};
  int err_total = 0;
  int total_checks = 0;
  int n, n0;
  `define CHK(a, b) chk((a) === (b))
  asp_top u_asp_top (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .RXD(RXD), .TXD(TXD), .IRQ(IRQ));
  asp_rem u_asp_rem (.clk(SYS_CLK), .txd(TXD), .rxd(RXD));
  initial begin
    SYS_CLK = 1'b0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end
  task automatic chk(input bit ok);
    total_checks++;
    if (!ok) begin
      err_total++;
      $display("wrong value at %0t: mismatch", $time);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] x);
    @(posedge SYS_CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= x;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge SYS_CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask
  task automatic wait_stat(input int b);
    n = 0;
    do begin
      rd(8'h82);
      n++;
    end while (v[b] !== 1'b1 && n < 300);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge SYS_CLK);
    err_total++;
    stop_test();
  end
  initial begin
    RST = 1'b1;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 8'h00;
    WDATA = 16'h0000;
    repeat (5) @(posedge SYS_CLK);
    RST <= 1'b0;
    rd(8'h80); `CHK(v, 16'h0000);
    rd(8'h88); `CHK(v, 16'h0000);
    rd(8'h8A); `CHK(v, 16'h0000);
    wr(8'h88, 16'h0001);
    rd(8'h88); `CHK(v, 16'h0001);
    for (int m = 0; m < 3; m++) begin
      u_asp_rem.nb = cfg[m][4] ? 8 : 7;
      u_asp_rem.pm = cfg[m][6:5];
      u_asp_rem.ns = cfg[m][3] ? 2 : 1;
      mk = cfg[m][4] ? 8'hFF : 8'h7F;
      d = cfg[m][4] ? 8'hA5 : 8'h5A;
      n0 = u_asp_rem.n_got;
      wr(8'h80, cfg[m]);
      wr(8'h84, {8'h00, ~d});
      rd(8'h82); `CHK(v[5], 1'b0);
      `CHK(TXD, 1'b1);
      wr(8'h80, cfg[m] | 16'h0005);
      rd(8'h80); `CHK(v, cfg[m] | 16'h0005);
      u_asp_rem.send(d, 1'b0, 1'b1);
      wait_stat(4); `CHK(v[4:0], 5'h10);
      rd(8'h86); `CHK(v, {8'h00, d});
      for (n = 0; u_asp_rem.n_got == n0 && n < 400; n++) @(posedge SYS_CLK);
      `CHK(u_asp_rem.got, ~d & mk);
      if (cfg[m][6]) `CHK(u_asp_rem.got_p, cfg[m][5] ^~ ^(~d & mk));
      `CHK(u_asp_rem.got_stop, 1'b1);
    end
    u_asp_rem.ns = 1;
    wr(8'h80, 16'h0077);
    u_asp_rem.send(8'h81, 1'b1, 1'b1);
    wait_stat(1); `CHK(IRQ, 1'b1);
    u_asp_rem.send(8'h81, 1'b0, 1'b0);
    wait_stat(2); `CHK(v[2], 1'b1);
    u_asp_rem.send(8'h00, 1'b0, 1'b0);
    wait_stat(3); `CHK(v[3], 1'b1);
    rd(8'h82); `CHK(v[3:1], 3'h7);
    rd(8'h86);
    wr(8'h82, 16'h0000);
    rd(8'h82); `CHK(v[3:0], 4'h0);
    u_asp_rem.send(8'h11, 1'b0, 1'b1);
    u_asp_rem.send(8'h22, 1'b0, 1'b1);
    wait_stat(0); `CHK(v[0], 1'b1);
    rd(8'h86); `CHK(v[7:0], 8'h11);
    rd(8'h82); `CHK(v[4], 1'b0);
    wr(8'h82, 16'h0000);
    u_asp_rem.pm = 2'h0;
    wr(8'h80, 16'h0415);
    u_asp_rem.send(8'h5A, 1'b0, 1'b1);
    wait_stat(4); `CHK(IRQ, 1'b1);
    rd(8'h86);
    repeat (3) @(posedge SYS_CLK);
    `CHK(IRQ, 1'b0);
    wr(8'h80, 16'h0814);
    repeat (3) @(posedge SYS_CLK);
    `CHK(IRQ, 1'b1);
    n0 = u_asp_rem.n_got;
    wr(8'h80, 16'h0215);
    wr(8'h84, 16'h0069);
    wait_stat(4);
    rd(8'h86); `CHK(v, 16'h0069);
    `CHK(u_asp_rem.n_got, n0);
    wr(8'h80, 16'h0014);
    wait_stat(6);
    wr(8'h80, 16'h0114);
    wr(8'h84, 16'h00FF);
    for (n = 0; TXD && n < 100; n++) @(posedge SYS_CLK);
    for (n = 0; !TXD && n < 1000; n++) @(posedge SYS_CLK);
    `CHK(n, 160);
    stop_test();
  end
endmodule
bind asp_top asp_monitor u_asp_monitor (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RXD(RXD), .TXD(TXD), .IRQ(IRQ));

// ### verilog/asp_pkg.sv
// Purpose: types of the serial port
// Assumes: asp_regs.svh holds all numbers
// Notes: none
package asp_pkg;
  typedef enum logic [1:0] {
    ASP_IDLE = 2'h0,
    ASP_START = 2'h1,
    ASP_BITS = 2'h3,
    ASP_STOP = 2'h2
  } asp_state_t;
  typedef struct packed {
    logic [15:0] addr_unused;
  } asp_pad_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } asp_req_t;
endpackage

// ### verilog/asp_regs.svh
// Purpose: register offsets, field positions and constants of the serial port
// Assumes: byte offsets on the register port
// Notes: definitions only
`ifndef ASP_REGS_SVH
`define ASP_REGS_SVH
`define ASP_ADDR_W 8
`define ASP_OFS_CTRL 8'h80
`define ASP_OFS_STAT 8'h82
`define ASP_OFS_TXD 8'h84
`define ASP_OFS_RXD 8'h86
`define ASP_OFS_DIV 8'h88
`define ASP_CTRL_RST 16'h0000
`define ASP_DIV_RST 16'h0000
`define ASP_CTRL_MASK 16'h0FFF
`define ASP_B_TX_READY_IRQ_EN 11
`define ASP_B_RX_READY_IRQ_EN 10
`define ASP_B_LOOP 9
`define ASP_B_BRK 8
`define ASP_B_BRKLVL 7
`define ASP_B_PEN 6
`define ASP_B_PEVEN 5
`define ASP_B_W8 4
`define ASP_B_STP2 3
`define ASP_B_TXEN 2
`define ASP_B_RX_STATUS_IRQ_EN 1
`define ASP_B_RXEN 0
`define ASP_S_SHEMPTY 6
`define ASP_S_HOLDEMPTY 5
`define ASP_S_RXVALID 4
`define ASP_S_BREAK 3
`define ASP_S_FRAME 2
`define ASP_S_PARITY 1
`define ASP_S_OVERRUN 0
`define ASP_OVS_LAST 4'hF
`define ASP_OVS_MID 4'h7
`endif

// ### verilog/asp_top.sv
// Purpose: full-duplex asynchronous serial port with register port
// Assumes: SYS_CLK 10 MHz, RST synchronous active high
// Notes: frame bits are 16 ticks of the divided rate; divisor 0 stops the tick
`timescale 1ns/1ps
`include "asp_regs.svh"

// Functional notes
// - separate transmit and receive lines run together, no handshake lines
// - bit rate is clock divided by sixteen times the divisor register
// - transmit-ready enable raises interrupt while holding register empty
// - receive-ready enable raises interrupt while received data valid
// - loopback feeds transmit into receiver and holds transmit line high
// - break plus data write sends one frame of break_level on transmit line
// - parity select: 0x none, 10 odd, 11 even; generated and checked
// - word length select: 1 gives eight data bits, 0 gives seven
// - stop count select: 1 gives two stop bits, 0 gives one
// - transmit section starts a frame only while transmit enable is set
// - receive section runs only while receive enable is set
// - receive status enable lets receive errors and break interrupt
// - shifter empty flag set while transmit shift register holds nothing
// - holding empty set when free, cleared at transmit data write
// - receive valid set on new byte, cleared by receive data read
// - break seen set on received break, held until software clears it
// - framing error set on bad stop bit, held until software clears it
// - parity error set on parity mismatch, held until software clears it
// - overrun error set on overrun, held until software clears it
module asp_top
  import asp_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // serial link
  input wire logic RXD,
  output logic TXD,
  // interrupt request
  output logic IRQ
);

  asp_req_t req;
  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  logic [15:0] ctrl;
  logic [15:0] divisor;
  logic [15:0] status;
  logic [7:0] rx_buf;
  logic hold_full, shift_busy, rx_valid;
  logic break_seen, framing_err, parity_err, overrun_err;

  wire wr_ctrl = req.wr && (req.addr == `ASP_OFS_CTRL);
  wire wr_stat = req.wr && (req.addr == `ASP_OFS_STAT);
  wire wr_txd = req.wr && (req.addr == `ASP_OFS_TXD);
  wire wr_div = req.wr && (req.addr == `ASP_OFS_DIV);
  wire rd_rxd = req.rd && (req.addr == `ASP_OFS_RXD);

  wire pen = ctrl[`ASP_B_PEN];
  wire peven = ctrl[`ASP_B_PEVEN];
  wire w8 = ctrl[`ASP_B_W8];
  wire stp2 = ctrl[`ASP_B_STP2];
  wire txen = ctrl[`ASP_B_TXEN];
  wire rxen = ctrl[`ASP_B_RXEN];
  wire loop_sel = ctrl[`ASP_B_LOOP];

  assign status = {9'h000, ~shift_busy, ~hold_full, rx_valid,
                   break_seen, framing_err, parity_err, overrun_err};

  logic [15:0] next_rdata;
  always_comb begin
    case (req.addr)
      `ASP_OFS_CTRL: next_rdata = ctrl;
      `ASP_OFS_STAT: next_rdata = status;
      `ASP_OFS_RXD: next_rdata = {8'h00, rx_buf};
      `ASP_OFS_DIV: next_rdata = divisor;
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl <= `ASP_CTRL_RST;
      divisor <= `ASP_DIV_RST;
      RDATA <= 16'h0000;
    end else begin
      if (wr_ctrl)
        ctrl <= req.wdata & `ASP_CTRL_MASK;
      if (wr_div)
        divisor <= req.wdata;
      RDATA <= req.rd ? next_rdata : 16'h0000;
    end
  end

  // ------------------------------------------------------------
  // baud tick: one pulse per sixteenth of a bit
  // ------------------------------------------------------------
  logic [15:0] div_cnt;
  logic tick;
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (divisor == 16'h0000) begin
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (div_cnt >= divisor - 16'h0001) begin
      div_cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  // start plus data bits plus parity plus stops; parity over the data bits
  function automatic logic par_bit(input logic [7:0] d, input logic eight, input logic even);
    logic p;
    p = ^(eight ? d : {1'b0, d[6:0]});
    par_bit = even ? p : ~p;
  endfunction

  // ------------------------------------------------------------
  // transmitter
  // ------------------------------------------------------------
  asp_state_t tx_state;
  logic [7:0] hold_reg;
  logic hold_brk;
  logic [10:0] tx_shift;
  logic [3:0] tx_bits, tx_ovs;
  logic tx_is_brk, tx_line;

  wire tx_load = txen && hold_full && !shift_busy;
  wire [3:0] tx_len = 4'h1 + (w8 ? 4'h8 : 4'h7) + {3'h0, pen} + (stp2 ? 4'h2 : 4'h1);
  wire tx_par = par_bit(hold_reg, w8, peven);
  logic [10:0] tx_frame;
  always_comb begin
    tx_frame = 11'h7FF;
    tx_frame[0] = 1'b0;
    if (w8) begin
      tx_frame[8:1] = hold_reg;
      if (pen) tx_frame[9] = tx_par;
    end else begin
      tx_frame[7:1] = hold_reg[6:0];
      if (pen) tx_frame[8] = tx_par;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      tx_state <= ASP_IDLE;
      hold_full <= 1'b0;
      hold_reg <= 8'h00;
      hold_brk <= 1'b0;
      shift_busy <= 1'b0;
      tx_shift <= 11'h7FF;
      tx_bits <= 4'h0;
      tx_ovs <= 4'h0;
      tx_is_brk <= 1'b0;
      tx_line <= 1'b1;
    end else begin
      if (wr_txd) begin
        hold_reg <= req.wdata[7:0];
        hold_brk <= ctrl[`ASP_B_BRK];
        hold_full <= 1'b1;
      end else if (tx_load)
        hold_full <= 1'b0;
      case (tx_state)
        ASP_IDLE: begin
          tx_line <= 1'b1;
          if (tx_load) begin
            shift_busy <= 1'b1;
            tx_shift <= tx_frame;
            tx_is_brk <= hold_brk;
            tx_bits <= tx_len;
            tx_ovs <= 4'h0;
            tx_state <= ASP_BITS;
          end
        end
        ASP_BITS: begin
          tx_line <= tx_is_brk ? ctrl[`ASP_B_BRKLVL] : tx_shift[0];
          if (tick) begin
            tx_ovs <= tx_ovs + 4'h1;
            if (tx_ovs == `ASP_OVS_LAST) begin
              tx_shift <= {1'b1, tx_shift[10:1]};
              tx_bits <= tx_bits - 4'h1;
              // the last bit keeps its full length; idle drives the line high next
              if (tx_bits == 4'h1) begin
                tx_state <= ASP_IDLE;
                shift_busy <= 1'b0;
              end
            end
          end
        end
        default: tx_state <= ASP_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // receiver input: three flops, change taken once two agree
  // ------------------------------------------------------------
  logic rx_s1, rx_s2, rx_s3, rx_in;
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
      rx_in <= 1'b1;
    end else begin
      rx_s1 <= RXD;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3)
        rx_in <= rx_s3;
    end
  end
  wire rx_line = loop_sel ? tx_line : rx_in;

  // ------------------------------------------------------------
  // receiver
  // ------------------------------------------------------------
  asp_state_t rx_state;
  logic [9:0] rx_shift;
  logic [3:0] rx_bits, rx_ovs;
  logic rx_nonzero;
  // a low stop must go high again before a new start is taken
  logic rx_wait_hi;
  wire [3:0] rx_len = (w8 ? 4'h8 : 4'h7) + {3'h0, pen};
  wire mid = tick && (rx_ovs == `ASP_OVS_MID);
  // data and parity sit at the top of rx_shift once all bits are in
  wire [9:0] rx_al = w8 ? (pen ? {1'b0, rx_shift[9:1]} : {2'b00, rx_shift[9:2]})
                        : (pen ? {2'b00, rx_shift[9:2]} : {3'b000, rx_shift[9:3]});
  wire [7:0] rx_data = w8 ? rx_al[7:0] : {1'b0, rx_al[6:0]};
  wire rx_pbit = w8 ? rx_al[8] : rx_al[7];
  wire rx_done = (rx_state == ASP_STOP) && mid;
  wire got_brk = rx_done && !rx_line && !rx_nonzero;
  wire got_fer = rx_done && !rx_line && rx_nonzero;
  wire got_per = rx_done && pen && (rx_pbit != par_bit(rx_data, w8, peven));
  wire got_chr = rx_done && !got_brk;

  always_ff @(posedge SYS_CLK) begin
    if (RST || !rxen) begin
      rx_state <= ASP_IDLE;
      rx_shift <= 10'h000;
      rx_bits <= 4'h0;
      rx_ovs <= 4'h0;
      rx_nonzero <= 1'b0;
      rx_wait_hi <= 1'b0;
    end else begin
      if (tick)
        rx_ovs <= rx_ovs + 4'h1;
      if (rx_line)
        rx_wait_hi <= 1'b0;
      else if (rx_done)
        rx_wait_hi <= 1'b1;
      case (rx_state)
        ASP_IDLE: begin
          rx_ovs <= 4'h0;
          rx_nonzero <= 1'b0;
          if (!rx_line && !rx_wait_hi)
            rx_state <= ASP_START;
        end
        ASP_START: if (mid) begin
          if (rx_line)
            rx_state <= ASP_IDLE;
          else begin
            rx_bits <= rx_len;
            rx_state <= ASP_BITS;
          end
        end
        ASP_BITS: if (mid) begin
          rx_shift <= {rx_line, rx_shift[9:1]};
          rx_nonzero <= rx_nonzero | rx_line;
          rx_bits <= rx_bits - 4'h1;
          if (rx_bits == 4'h1)
            rx_state <= ASP_STOP;
        end
        ASP_STOP: if (mid) rx_state <= ASP_IDLE;
        default: rx_state <= ASP_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // receive buffer and sticky flags; the set wins over the clear
  // ------------------------------------------------------------
  wire [15:0] clr = wr_stat ? ~req.wdata : 16'h0000;
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rx_buf <= 8'h00;
      rx_valid <= 1'b0;
      break_seen <= 1'b0;
      framing_err <= 1'b0;
      parity_err <= 1'b0;
      overrun_err <= 1'b0;
    end else begin
      if (got_chr && !rx_valid)
        rx_buf <= rx_data;
      if (got_chr)
        rx_valid <= 1'b1;
      else if (rd_rxd)
        rx_valid <= 1'b0;
      break_seen <= got_brk | (break_seen & ~clr[`ASP_S_BREAK]);
      framing_err <= got_fer | (framing_err & ~clr[`ASP_S_FRAME]);
      parity_err <= got_per | (parity_err & ~clr[`ASP_S_PARITY]);
      overrun_err <= (got_chr & rx_valid & ~rd_rxd)
                     | (overrun_err & ~clr[`ASP_S_OVERRUN]);
    end
  end

  // ------------------------------------------------------------
  // pins and interrupt
  // ------------------------------------------------------------
  wire rs_irq = ctrl[`ASP_B_RX_STATUS_IRQ_EN] & (break_seen | framing_err | parity_err | overrun_err);
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      TXD <= 1'b1;
      IRQ <= 1'b0;
    end else begin
      TXD <= loop_sel ? 1'b1 : tx_line;
      IRQ <= (ctrl[`ASP_B_TX_READY_IRQ_EN] & ~hold_full)
             | (ctrl[`ASP_B_RX_READY_IRQ_EN] & rx_valid)
             | rs_irq;
    end
  end

endmodule
